// ==== common/gsl_consts.svh ====
// register offsets, field positions and reset values for the sensing port
`ifndef GSL_CONSTS_SVH
`define GSL_CONSTS_SVH

`define GSL_NPINS          32
`define GSL_OFF_OUT        12'h004
`define GSL_OFF_OUTSET     12'h008
`define GSL_OFF_OUTCLR     12'h00C
`define GSL_OFF_IN         12'h010
`define GSL_OFF_DIR        12'h014
`define GSL_OFF_DIRSET     12'h018
`define GSL_OFF_DIRCLR     12'h01C
`define GSL_OFF_LATCH      12'h020
`define GSL_OFF_MODE       12'h024
`define GSL_OFF_MODE_SEC   12'h028
`define GSL_OFF_PIN_OWNERSHIP_MAP       12'h030
`define GSL_OFF_CNF        12'h200
`define GSL_OFF_CNF_END    12'h27C

`define GSL_CNF_DIR_BIT    0
`define GSL_CNF_INBUF_BIT  1
`define GSL_CNF_PULL_LSB   2
`define GSL_CNF_DRIVE_LSB  8
`define GSL_CNF_SENSE_LSB  16
`define GSL_CNF_MASK       32'h00030F0F
`define GSL_CNF_RESET      32'h00000002

`define GSL_SENSE_OFF      2'h0
`define GSL_SENSE_HIGH     2'h2
`define GSL_SENSE_LOW      2'h3

`define GSL_SYNC_CYC       2
`define GSL_REARM_CYC      3

`endif

// ==== common/gsl_pkg.sv ====
// types shared by the sensing port
package gsl_pkg;
  typedef enum logic [1:0] {
    GSL_SENSE_OFF_E  = 2'h0,
    GSL_SENSE_RSV_E  = 2'h1,
    GSL_SENSE_HIGH_E = 2'h2,
    GSL_SENSE_LOW_E  = 2'h3
  } gsl_sense_t;

  typedef enum logic [1:0] {
    GSL_HT_IDLE   = 2'h0,
    GSL_HT_BUSY   = 2'h1,
    GSL_HT_NONSEQ = 2'h2,
    GSL_HT_SEQ    = 2'h3
  } gsl_htrans_t;
endpackage : gsl_pkg

// ==== verilog/gsl_port.sv ====
// 32-pin port: level sensing, capture bits, match outputs, secure filtering
`include "gsl_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module gsl_port
  import gsl_pkg::*;
#(
  parameter int NPINS = `GSL_NPINS
) (
  // clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_B,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [11:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic              HNONSEC,
  input  wire logic [31:0]       HWDATA,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire logic              HREADY,
  // pins
  input  wire logic [NPINS-1:0]  PIN_IN,
  output logic      [NPINS-1:0]  PIN_OUT,
  output logic      [NPINS-1:0]  PIN_OE,
  // match outputs to event units
  output logic                   NONSECURE_PORT_MATCH,
  output logic                   SECURE_PORT_MATCH,
  output logic      [NPINS-1:0]  PIN_MATCH
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] latch_q;
  logic [NPINS-1:0] pin_ownership_map_q;
  logic [31:0]      cnf_q [NPINS];
  logic             mode_q;
  logic             mode_sec_q;
  logic [NPINS-1:0] sync1_q;
  logic [NPINS-1:0] sync2_q;
  logic [NPINS-1:0] match_q;
  logic [NPINS-1:0] match_prev_q;
  logic             ldrop_q;

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic        ap_valid_q;
  logic        ap_write_q;
  logic        ap_nonsec_q;
  logic [11:0] ap_addr_q;
  logic        ap_take;
  assign ap_take = HSEL && HREADY && (HTRANS == GSL_HT_NONSEQ || HTRANS == GSL_HT_SEQ);

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ap_valid_q  <= 1'b0;
      ap_write_q  <= 1'b0;
      ap_nonsec_q <= 1'b0;
      ap_addr_q   <= 12'h000;
    end else if (HREADY) begin
      ap_valid_q  <= ap_take;
      ap_write_q  <= HWRITE;
      ap_nonsec_q <= HNONSEC;
      ap_addr_q   <= {HADDR[11:2], 2'b00};
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  logic             wr;
  logic [NPINS-1:0] wmask;
  logic [NPINS-1:0] wd;
  logic             cnf_hit;
  logic [4:0]       cnf_idx;
  assign wr      = ap_valid_q && ap_write_q;
  assign wmask   = ap_nonsec_q ? ~pin_ownership_map_q : {NPINS{1'b1}};
  assign wd      = HWDATA[NPINS-1:0] & wmask;
  assign cnf_hit = ap_addr_q >= `GSL_OFF_CNF && ap_addr_q <= `GSL_OFF_CNF_END;
  assign cnf_idx = ap_addr_q[6:2];

  //////////////////////////////////////////////////////////////////////////////
  // output and direction registers
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
    end else if (wr) begin
      unique case (ap_addr_q)
        `GSL_OFF_OUT:    out_q <= (out_q & ~wmask) | wd;
        `GSL_OFF_OUTSET: out_q <= out_q | wd;
        `GSL_OFF_OUTCLR: out_q <= out_q & ~wd;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= '0;
    end else if (wr) begin
      unique case (ap_addr_q)
        `GSL_OFF_DIR:    dir_q <= (dir_q & ~wmask) | wd;
        `GSL_OFF_DIRSET: dir_q <= dir_q | wd;
        `GSL_OFF_DIRCLR: dir_q <= dir_q & ~wd;
        default: ;
      endcase
    end
  end

  // pin ownership map: secure accesses only
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_ownership_map_q <= '0;
    end else if (wr && !ap_nonsec_q && ap_addr_q == `GSL_OFF_PIN_OWNERSHIP_MAP) begin
      pin_ownership_map_q <= HWDATA[NPINS-1:0];
    end
  end

  // source selects
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_q     <= 1'b0;
      mode_sec_q <= 1'b0;
    end else if (wr) begin
      if (ap_addr_q == `GSL_OFF_MODE) begin
        mode_q <= HWDATA[0];
      end
      if (ap_addr_q == `GSL_OFF_MODE_SEC && !ap_nonsec_q) begin
        mode_sec_q <= HWDATA[0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-pin configuration words
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_cnf
      always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          cnf_q[g] <= `GSL_CNF_RESET;
        end else if (wr && cnf_hit && cnf_idx == 5'(g)
                     && !(ap_nonsec_q && pin_ownership_map_q[g])) begin
          cnf_q[g] <= HWDATA & `GSL_CNF_MASK;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // input sync and sensing
  logic [NPINS-1:0] inbuf_on;
  logic [NPINS-1:0] match_d;
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      inbuf_on[i] = ~cnf_q[i][`GSL_CNF_INBUF_BIT];
      unique case (gsl_sense_t'(cnf_q[i][`GSL_CNF_SENSE_LSB +: 2]))
        GSL_SENSE_HIGH_E: match_d[i] = inbuf_on[i] & sync2_q[i];
        GSL_SENSE_LOW_E:  match_d[i] = inbuf_on[i] & ~sync2_q[i];
        default:          match_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= PIN_IN;
      sync2_q <= sync1_q;
    end
  end

  // sensing runs from MCLK regardless of power state
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      match_q      <= '0;
      match_prev_q <= '0;
    end else begin
      match_q      <= match_d;
      match_prev_q <= match_q;
    end
  end
  assign PIN_MATCH = match_q;

  //////////////////////////////////////////////////////////////////////////////
  // capture bits
  logic [NPINS-1:0] rise;
  logic [NPINS-1:0] clr;
  logic             latch_clr_wr;
  assign rise         = match_q & ~match_prev_q;
  assign latch_clr_wr = wr && ap_addr_q == `GSL_OFF_LATCH;
  assign clr          = latch_clr_wr ? (wd & ~match_q) : '0;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= '0;
    end else begin
      latch_q <= (latch_q & ~clr) | rise;
    end
  end

  // one-cycle drop after a clear that leaves bits set
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ldrop_q <= 1'b0;
    end else begin
      ldrop_q <= latch_clr_wr && (|wd);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port match outputs
  logic ldet_ns;
  logic ldet_s;
  logic det_ns_q;
  logic det_s_q;
  assign ldet_ns = |(latch_q & ~pin_ownership_map_q) && !ldrop_q;
  assign ldet_s  = |(latch_q & pin_ownership_map_q) && !ldrop_q;
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      det_ns_q <= 1'b0;
      det_s_q  <= 1'b0;
    end else begin
      det_ns_q <= mode_q ? ldet_ns : |(match_q & ~pin_ownership_map_q);
      det_s_q  <= mode_sec_q ? ldet_s : |(match_q & pin_ownership_map_q);
    end
  end
  assign NONSECURE_PORT_MATCH = det_ns_q;
  assign SECURE_PORT_MATCH    = det_s_q;

  //////////////////////////////////////////////////////////////////////////////
  // pin drive
  assign PIN_OUT = out_q;
  assign PIN_OE  = dir_q;

  //////////////////////////////////////////////////////////////////////////////
  // read data
  logic [NPINS-1:0] rmask;
  logic [31:0]      rdata;
  assign rmask = ap_nonsec_q ? ~pin_ownership_map_q : {NPINS{1'b1}};
  always_comb begin
    rdata = 32'h00000000;
    if (cnf_hit) begin
      rdata = (ap_nonsec_q && pin_ownership_map_q[cnf_idx]) ? 32'h00000000 : cnf_q[cnf_idx];
    end else begin
      unique case (ap_addr_q)
        `GSL_OFF_OUT, `GSL_OFF_OUTSET, `GSL_OFF_OUTCLR: rdata = 32'(out_q & rmask);
        `GSL_OFF_IN:      rdata = 32'(sync2_q & inbuf_on & rmask);
        `GSL_OFF_DIR, `GSL_OFF_DIRSET, `GSL_OFF_DIRCLR: rdata = 32'(dir_q & rmask);
        `GSL_OFF_LATCH:   rdata = 32'(latch_q & rmask);
        `GSL_OFF_MODE:    rdata = {31'h0, mode_q};
        `GSL_OFF_MODE_SEC: rdata = {31'h0, mode_sec_q & !ap_nonsec_q};
        `GSL_OFF_PIN_OWNERSHIP_MAP:    rdata = ap_nonsec_q ? 32'h0 : 32'(pin_ownership_map_q);
        default:          rdata = 32'h00000000;
      endcase
    end
  end
  assign HRDATA = (ap_valid_q && !ap_write_q) ? rdata : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_pin_rise(int i);
    !match_q[i] ##1 match_q[i];
  endsequence

  sequence s_latch_clear0;
    latch_clr_wr && wd[0] && !match_q[0];
  endsequence

  AST_IN_DELAY: assert property (@(posedge MCLK) disable iff (!rst_n)
    ##2 (sync2_q == $past(PIN_IN, 2)))
    else $error("input register not two cycles behind pad");
  AST_LATCH_SET: assert property (@(posedge MCLK) disable iff (!rst_n)
    s_pin_rise(0) |=> latch_q[0])
    else $error("capture bit 0 not set on match rise");
  AST_LATCH_HOLD: assert property (@(posedge MCLK) disable iff (!rst_n)
    (latch_clr_wr && match_q[0] && latch_q[0]) |=> latch_q[0])
    else $error("capture bit cleared while match high");
  AST_LATCH_STICKY: assert property (@(posedge MCLK) disable iff (!rst_n)
    (latch_q[0] && !latch_clr_wr) |=> latch_q[0])
    else $error("capture bit dropped without clear");
  AST_LDROP: assert property (@(posedge MCLK) disable iff (!rst_n)
    (latch_clr_wr && |wd && mode_q) |=> ##1 !det_ns_q)
    else $error("latched match did not drop after clear");
  AST_DIRECT: assert property (@(posedge MCLK) disable iff (!rst_n)
    !mode_q |=> (det_ns_q == $past(|(match_q & ~pin_ownership_map_q))))
    else $error("merged port match wrong");
  AST_SEC_WR: assert property (@(posedge MCLK) disable iff (!rst_n)
    (wr && ap_nonsec_q && pin_ownership_map_q[0]) |=> $stable(out_q[0]) && $stable(dir_q[0]))
    else $error("non-secure write changed secure pin");
  AST_SEC_MODE: assert property (@(posedge MCLK) disable iff (!rst_n)
    (wr && ap_nonsec_q && ap_addr_q == `GSL_OFF_MODE_SEC) |=> $stable(mode_sec_q))
    else $error("non-secure write changed secure source select");
  AST_OKAY: assert property (@(posedge MCLK) disable iff (!rst_n)
    HREADYOUT && !HRESP)
    else $error("bus response not okay");
  AST_BUF_OFF: assert property (@(posedge MCLK) disable iff (!rst_n)
    cnf_q[0][`GSL_CNF_INBUF_BIT] |=> !match_q[0])
    else $error("disconnected pin matched");
  AST_CLR: assert property (@(posedge MCLK) disable iff (!rst_n)
    s_latch_clear0 |=> !latch_q[0])
    else $error("capture bit 0 not cleared by write of one");
  AST_LATCH_HIGH: assert property (@(posedge MCLK) disable iff (!rst_n)
    (mode_q && |(latch_q & ~pin_ownership_map_q) && !ldrop_q) |=> det_ns_q)
    else $error("latched match low while capture bits set");
  AST_LATCH_LOW: assert property (@(posedge MCLK) disable iff (!rst_n)
    (mode_q && latch_q == '0) |=> !det_ns_q)
    else $error("latched match high with no capture bit");
  AST_NS_ONLY: assert property (@(posedge MCLK) disable iff (!rst_n)
    (!mode_q && (match_q & ~pin_ownership_map_q) == '0) |=> !det_ns_q)
    else $error("secure pin reached non-secure port match");
  AST_SEC_DIRECT: assert property (@(posedge MCLK) disable iff (!rst_n)
    !mode_sec_q |=> (det_s_q == $past(|(match_q & pin_ownership_map_q))))
    else $error("secure merged port match wrong");
  AST_MATCH_HIGH: assert property (@(posedge MCLK) disable iff (!rst_n)
    (cnf_q[0][`GSL_CNF_SENSE_LSB +: 2] == `GSL_SENSE_HIGH
     && !cnf_q[0][`GSL_CNF_INBUF_BIT] && sync2_q[0]) |=> match_q[0])
    else $error("pin 0 high level not matched");
  AST_SEC_CNF: assert property (@(posedge MCLK) disable iff (!rst_n)
    (wr && ap_nonsec_q && cnf_hit && cnf_idx == 5'h0 && pin_ownership_map_q[0]) |=> $stable(cnf_q[0]))
    else $error("non-secure write changed secure pin config");
  AST_SEC_RD: assert property (@(posedge MCLK) disable iff (!rst_n)
    (ap_valid_q && !ap_write_q && ap_nonsec_q && cnf_hit && pin_ownership_map_q[cnf_idx])
    |-> HRDATA == 32'h00000000)
    else $error("non-secure read showed secure pin config");
  AST_SEC_RDMASK: assert property (@(posedge MCLK) disable iff (!rst_n)
    (ap_valid_q && !ap_write_q && ap_nonsec_q && pin_ownership_map_q[0]
     && ap_addr_q >= `GSL_OFF_OUT && ap_addr_q <= `GSL_OFF_LATCH) |-> !HRDATA[0])
    else $error("non-secure read showed secure pin bit");

endmodule : gsl_port

`default_nettype wire

// ==== bench/gsl_pad_model.sv ====
// pad model: external circuitry on the port pins
`timescale 1ns/10ps
`default_nettype none

module gsl_pad_model #(
  parameter int NPINS = 32
) (
  // device side
  input  wire logic [NPINS-1:0] pin_out,
  input  wire logic [NPINS-1:0] pin_oe,
  // level the external driver holds
  input  wire logic [NPINS-1:0] ext_lvl,
  // pad level seen by the port
  output logic      [NPINS-1:0] pin_in
);
  // a pad driven by the port follows it, else the external driver
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : gsl_pad_model

`default_nettype wire

// ==== bench/test_gsl_port.sv ====
// self-checking bench for the sensing port
`include "gsl_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module test_gsl_port;
  import gsl_pkg::*;
  logic        mclk, rst_b, hsel, hwrite, hnonsec, hreadyout, hresp, ns_m, s_m, seen;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, ext, pin_in, pin_out, pin_oe, pin_m;
  int          err_count, cmp_count, cycles;

  gsl_port dut (.MCLK(mclk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HNONSEC(hnonsec), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HREADY(hreadyout), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .NONSECURE_PORT_MATCH(ns_m),
    .SECURE_PORT_MATCH(s_m), .PIN_MATCH(pin_m));
  gsl_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count = err_count + 1;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic bus(input logic w, input logic ns, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    haddr   <= a;
    hwrite  <= w;
    hnonsec <= ns;
    htrans  <= GSL_HT_NONSEQ;
    hsel    <= 1'b1;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= GSL_HT_IDLE;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdat = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic ns, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ns, a, d, x);
  endtask : wr

  task automatic rd(input logic ns, input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] x;
    bus(1'b0, ns, a, 32'h0, x);
    chk(n, e, x);
  endtask : rd
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0; hsel = 1'b0; haddr = 12'h0; htrans = 2'h0; hwrite = 1'b0;
    hnonsec = 1'b0; hwdata = 32'h0; ext = 32'h0; err_count = 0; cmp_count = 0; cycles = 0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(4);
    rd(0, `GSL_OFF_CNF, `GSL_CNF_RESET, "cnf0");
    rd(0, `GSL_OFF_OUT, 32'h0, "out");
    rd(0, `GSL_OFF_LATCH, 32'h0, "capture");
    rd(0, 12'h040, 32'h0, "unmapped");
    wr(0, `GSL_OFF_OUT, 32'h10);
    wr(0, `GSL_OFF_OUTSET, 32'h21);
    wr(0, `GSL_OFF_OUTCLR, 32'h1);
    wr(0, `GSL_OFF_DIRSET, 32'h10);
    #1 chk("pin_out", 32'h30, pin_out);
    chk("pin_oe", 32'h10, pin_oe);
    rd(0, `GSL_OFF_OUTSET, 32'h30, "outset");
    $display("test reset and outputs done");
    // pin0 connected, pins 1 and 4 stay disconnected
    wr(0, `GSL_OFF_CNF, 32'h0);
    ext <= 32'h3;
    cyc(3);
    rd(0, `GSL_OFF_IN, 32'h1, "in");
    ext <= 32'h2;
    wr(0, `GSL_OFF_CNF, 32'h00020000);
    wr(0, `GSL_OFF_CNF + 12'h4, 32'h00020002);
    cyc(4);
    ext <= 32'h3;
    cyc(2);
    #1 chk("match early", 32'h0, pin_m);
    cyc(1);
    #1 chk("match", 32'h1, pin_m);
    cyc(1);
    #1 chk("port match", 32'h1, {31'h0, ns_m});
    wr(0, `GSL_OFF_CNF + 12'h8, 32'h00030000);
    cyc(3);
    #1 chk("match two", 32'h5, pin_m);
    rd(0, `GSL_OFF_LATCH, 32'h5, "capture set");
    wr(0, `GSL_OFF_LATCH, 32'h1);
    rd(0, `GSL_OFF_LATCH, 32'h5, "capture held");
    // non-matching levels held well past three cycles
    ext <= 32'h6;
    cyc(6);
    #1 chk("match off", 32'h0, pin_m);
    chk("port match off", 32'h0, {31'h0, ns_m});
    wr(0, `GSL_OFF_LATCH, 32'h0);
    rd(0, `GSL_OFF_LATCH, 32'h5, "capture kept");
    $display("test sensing done");
    wr(0, `GSL_OFF_MODE, 32'h1);
    cyc(3);
    #1 chk("latched out", 32'h1, {31'h0, ns_m});
    wr(0, `GSL_OFF_LATCH, 32'h1);
    seen = 1'b0;
    repeat (6) begin
      @(posedge mclk);
      #1 if (ns_m === 1'b0) seen = 1'b1;
    end
    chk("drop seen", 32'h1, {31'h0, seen});
    chk("re-rise", 32'h1, {31'h0, ns_m});
    rd(0, `GSL_OFF_LATCH, 32'h4, "capture left");
    wr(0, `GSL_OFF_LATCH, 32'h4);
    cyc(3);
    #1 chk("latched low", 32'h0, {31'h0, ns_m});
    wr(0, `GSL_OFF_MODE, 32'h0);
    $display("test capture done");
    wr(0, `GSL_OFF_PIN_OWNERSHIP_MAP, 32'h1);
    rd(1, `GSL_OFF_PIN_OWNERSHIP_MAP, 32'h0, "owner ns");
    wr(1, `GSL_OFF_CNF, 32'h0);
    rd(0, `GSL_OFF_CNF, 32'h00020000, "cnf0 kept");
    rd(1, `GSL_OFF_CNF, 32'h0, "cnf0 ns");
    wr(1, `GSL_OFF_OUTSET, 32'h3);
    rd(0, `GSL_OFF_OUT, 32'h32, "out filtered");
    ext <= 32'h7;
    cyc(6);
    rd(0, `GSL_OFF_IN, 32'h5, "in sec");
    rd(1, `GSL_OFF_IN, 32'h4, "in ns");
    #1 chk("sec match", 32'h1, {31'h0, s_m});
    chk("ns match", 32'h0, {31'h0, ns_m});
    wr(1, `GSL_OFF_MODE_SEC, 32'h1);
    rd(0, `GSL_OFF_MODE_SEC, 32'h0, "src sec");
    wr(0, `GSL_OFF_MODE_SEC, 32'h1);
    rd(1, `GSL_OFF_MODE_SEC, 32'h0, "src ns");
    rd(0, `GSL_OFF_MODE_SEC, 32'h1, "src set");
    // secure pin 0 captured, then its level drops: latched source keeps it high
    ext <= 32'h6;
    cyc(6);
    #1 chk("sec latched", 32'h1, {31'h0, s_m});
    wr(1, `GSL_OFF_LATCH, 32'h1);
    rd(0, `GSL_OFF_LATCH, 32'h1, "capture sec kept");
    rd(1, `GSL_OFF_LATCH, 32'h0, "capture sec ns");
    wr(0, `GSL_OFF_LATCH, 32'h1);
    cyc(3);
    #1 chk("sec latched low", 32'h0, {31'h0, s_m});
    $display("test security done");
    final_report();
  end
endmodule : test_gsl_port

`default_nettype wire
